// [core/temp_result_limit_alert.sv]
// Temperature result register, limit compare and alert outputs
//
// The register addresses and register access over APB were decided locally.
`include "temp_alert_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module temp_result_limit_alert #(
  parameter int RESULT_BITS = 14,
  parameter logic [15:0] NV_HIGH_FIRST = 16'h7ffc,
  parameter logic [15:0] NV_LOW_FIRST = 16'h8000,
  parameter logic [15:0] NV_HIGH_SECOND = 16'h7ffc,
  parameter logic [15:0] NV_LOW_SECOND = 16'h8000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire temp_alert_pkg::conv_t conv_in,
  input wire logic [7:0] bus_cmd,
  input wire logic bus_cmd_valid,
  output logic limit_out_first,
  output logic limit_out_second,
  output logic irq
);
  import temp_alert_pkg::*;

  if (RESULT_BITS != 14) begin : g_bad_width
    $error("RESULT_BITS must be 14");
  end

  // Receiver rate window, in hundreds of baud
  localparam int BAUD_MIN_HBD = `BAUD_MIN_HBD;
  localparam int BAUD_MAX_HBD = `BAUD_MAX_HBD;
  if (BAUD_MIN_HBD <= 0 || BAUD_MIN_HBD >= BAUD_MAX_HBD) begin : g_bad_baud
    $error("baud window must be non-empty");
  end

  logic [15:0] temp_ff;
  logic [7:0] cfg_ff;
  limit_pair_t lim_ff [2];
  logic [1:0] over_ff;
  logic [1:0] under_ff;
  logic [1:0] alert_ff;
  logic [1:0] status_ff;
  logic [1:0] enable_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic out_first_ff;
  logic out_second_ff;

  logic setup;
  logic wr;
  logic rd;
  logic cfg_read;
  logic [15:0] result_lj;
  logic [1:0] mode;
  logic [1:0] pol;
  logic [1:0] cmd_clear;
  logic [1:0] hi_hit;
  logic [1:0] lo_hit;
  logic [1:0] ev;

  function automatic logic known_addr(input logic [31:0] a);
    case (a[11:0])
      `OFS_TEMP, `OFS_CONFIG, `OFS_HIGH_FIRST, `OFS_LOW_FIRST,
      `OFS_HIGH_SECOND, `OFS_LOW_SECOND, `OFS_CLEAR_CMD,
      `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE, `OFS_IRQ_CLEAR: known_addr = (a[31:12] == 20'h0);
      default: known_addr = 1'b0;
    endcase
  endfunction : known_addr

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // One-cycle access phase
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready_ff && known_addr(paddr);
  assign rd = psel && penable && !pwrite && pready_ff;
  assign cfg_read = rd && (paddr[11:0] == `OFS_CONFIG) && (paddr[31:12] == 20'h0);
  // Left-justify the 14-bit code into 16 bits
  assign result_lj = {conv_in.code, 2'b00};
  assign mode = {cfg_ff[`CFG_MODE_SECOND], cfg_ff[`CFG_MODE_FIRST]};
  assign pol = {cfg_ff[`CFG_POL_SECOND], cfg_ff[`CFG_POL_FIRST]};
  // Clear commands from the serial receiver
  assign cmd_clear[0] = bus_cmd_valid && (bus_cmd == `CMD_CLEAR_FIRST);
  assign cmd_clear[1] = bus_cmd_valid && (bus_cmd == `CMD_CLEAR_SECOND);

  // Per-channel window compare
  generate
    for (genvar i = 0; i < 2; i++) begin : g_cmp
      assign hi_hit[i] = $signed(result_lj) > $signed(lim_ff[i].high);
      assign lo_hit[i] = $signed(result_lj) < $signed(lim_ff[i].low);
      assign ev[i] = conv_in.valid && (hi_hit[i] || (lo_hit[i] && !mode[i]));
    end
  endgenerate

  // Result register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_ff <= 16'h0000;
    end else if (conv_in.valid) begin
      temp_ff <= result_lj;
    end
  end

  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= `CFG_RESET;
    end else if (wr && paddr[11:0] == `OFS_CONFIG && pstrb[0]) begin
      cfg_ff <= pwdata[7:0];
    end
  end

  // Limit registers, nonvolatile defaults at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_ff[0] <= '{high: NV_HIGH_FIRST, low: NV_LOW_FIRST};
      lim_ff[1] <= '{high: NV_HIGH_SECOND, low: NV_LOW_SECOND};
    end else if (wr) begin
      case (paddr[11:0])
        `OFS_HIGH_FIRST: lim_ff[0].high <= merge16(lim_ff[0].high, pwdata, pstrb);
        `OFS_LOW_FIRST: lim_ff[0].low <= merge16(lim_ff[0].low, pwdata, pstrb);
        `OFS_HIGH_SECOND: lim_ff[1].high <= merge16(lim_ff[1].high, pwdata, pstrb);
        `OFS_LOW_SECOND: lim_ff[1].low <= merge16(lim_ff[1].low, pwdata, pstrb);
        default: ;
      endcase
    end
  end

  // Flags and alert state per channel
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      logic clr_cmd;
      assign clr_cmd = cmd_clear[i] ||
                       (wr && paddr[11:0] == `OFS_CLEAR_CMD && pwdata[i]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          over_ff[i] <= 1'b0;
          under_ff[i] <= 1'b0;
          alert_ff[i] <= 1'b0;
        end else if (mode[i]) begin
          // Therm: over and alert change only on a conversion, under is held at zero
          under_ff[i] <= 1'b0;
          if (conv_in.valid && hi_hit[i]) begin
            over_ff[i] <= 1'b1;
            alert_ff[i] <= 1'b1;
          end else if (conv_in.valid && lo_hit[i]) begin
            over_ff[i] <= 1'b0;
            alert_ff[i] <= 1'b0;
          end
        end else begin
          // Latched: new trip wins over a clear
          over_ff[i] <= (conv_in.valid && hi_hit[i]) ||
                        (over_ff[i] && !cfg_read);
          under_ff[i] <= (conv_in.valid && lo_hit[i]) ||
                         (under_ff[i] && !cfg_read);
          alert_ff[i] <= (conv_in.valid && (hi_hit[i] || lo_hit[i])) ||
                         (alert_ff[i] && !cfg_read && !clr_cmd);
        end
      end
    end
  endgenerate

  // Alert pins; each pin is its alert state XOR its polarity bit, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_first_ff <= 1'b0;
      out_second_ff <= 1'b0;
    end else begin
      out_first_ff <= alert_ff[0] ^ pol[0];
      out_second_ff <= alert_ff[1] ^ pol[1];
    end
  end

  // Interrupt status, enable and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 2'b00;
      enable_ff <= 2'b00;
      irq_ff <= 1'b0;
    end else begin
      if (wr && paddr[11:0] == `OFS_IRQ_ENABLE) begin
        enable_ff <= pwdata[1:0];
      end
      if (wr && paddr[11:0] == `OFS_IRQ_CLEAR) begin
        status_ff <= (status_ff & ~pwdata[1:0]) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
      irq_ff <= |(status_ff & enable_ff);
    end
  end

  // APB slave: answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !known_addr(paddr);
      prdata_ff <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr[11:0])
          `OFS_TEMP: prdata_ff <= {16'h0000, temp_ff};
          `OFS_CONFIG: prdata_ff <= {24'h0, cfg_ff[7:6], over_ff[0], under_ff[0] & ~mode[0],
                                     cfg_ff[3:2], over_ff[1],
                                     under_ff[1] & ~mode[1]};
          `OFS_HIGH_FIRST: prdata_ff <= {16'h0000, lim_ff[0].high};
          `OFS_LOW_FIRST: prdata_ff <= {16'h0000, lim_ff[0].low};
          `OFS_HIGH_SECOND: prdata_ff <= {16'h0000, lim_ff[1].high};
          `OFS_LOW_SECOND: prdata_ff <= {16'h0000, lim_ff[1].low};
          `OFS_IRQ_STATUS: prdata_ff <= {30'h0, status_ff};
          `OFS_IRQ_ENABLE: prdata_ff <= {30'h0, enable_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign limit_out_first = out_first_ff;
  assign limit_out_second = out_second_ff;
endmodule : temp_result_limit_alert
`default_nettype wire

// [core/temp_alert_cfg.svh]
// Offsets, field positions, reset values and constants of the temperature alert block
`ifndef TEMP_ALERT_CFG_SVH
`define TEMP_ALERT_CFG_SVH
`define OFS_TEMP 12'h000
`define OFS_CONFIG 12'h004
`define OFS_HIGH_FIRST 12'h008
`define OFS_LOW_FIRST 12'h00c
`define OFS_HIGH_SECOND 12'h010
`define OFS_LOW_SECOND 12'h014
`define OFS_CLEAR_CMD 12'h018
`define OFS_IRQ_STATUS 12'h01c
`define OFS_IRQ_ENABLE 12'h020
`define OFS_IRQ_CLEAR 12'h024
`define CFG_POL_FIRST 7
`define CFG_MODE_FIRST 6
`define CFG_OVER_FIRST 5
`define CFG_UNDER_FIRST 4
`define CFG_POL_SECOND 3
`define CFG_MODE_SECOND 2
`define CFG_OVER_SECOND 1
`define CFG_UNDER_SECOND 0
`define CFG_RESET 8'h00
`define CMD_CLEAR_FIRST 8'hb5
`define CMD_CLEAR_SECOND 8'h75
`define LIMIT_MAX_CODE 16'h7ffc
`define LIMIT_MIN_CODE 16'h8000
`define RES_LSB_SHIFT 2
`define BAUD_MIN_HBD 48
`define BAUD_MAX_HBD 1154
`endif

// [core/temp_alert_pkg.sv]
// Types shared by the temperature alert block
package temp_alert_pkg;
  typedef struct packed {
    logic valid;
    logic [13:0] code;
  } conv_t;
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } limit_pair_t;
  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_TRIP = 2'b10
  } ch_state_t;
endpackage : temp_alert_pkg

// [test/alert_host_model.sv]
// Host side model that issues the per-channel alert clear command bytes
`timescale 1ns/100ps
`default_nettype none
module alert_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic [7:0] code,
  output logic [7:0] bus_cmd,
  output logic bus_cmd_valid
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_cmd <= 8'h00;
      bus_cmd_valid <= 1'b0;
    end else begin
      bus_cmd_valid <= send;
      bus_cmd <= send ? code : ~bus_cmd;
    end
  end
endmodule : alert_host_model
`default_nettype wire

// [test/temp_alert_chk.sv]
// Concurrent checks on the temperature alert block ports
`timescale 1ns/100ps
`default_nettype none
module temp_alert_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire temp_alert_pkg::conv_t conv_in,
  input wire logic [7:0] bus_cmd,
  input wire logic bus_cmd_valid,
  input wire logic limit_out_first,
  input wire logic limit_out_second,
  input wire logic irq
);
  import temp_alert_pkg::*;
  logic [13:0] code_ff;
  logic [7:0] cfg_ff;
  wire logic acc = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_ff <= 14'h0000;
    end else if (conv_in.valid) begin
      code_ff <= conv_in.code;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 8'h00;
    end else if (acc && pwrite && paddr == 32'h4) begin
      cfg_ff <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_clr_first;
    bus_cmd_valid && bus_cmd == 8'hb5 && !cfg_ff[6] && !conv_in.valid;
  endsequence
  a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready is not a one cycle answer");
  a_unmapped_err: assert property (s_setup ##0 paddr[31:12] != 20'h0 |=> pslverr)
    else $error("unmapped access without error");
  a_temp_read: assert property (s_setup ##0 (!pwrite && paddr == 32'h0 && !conv_in.valid)
    |=> prdata == {16'h0, code_ff, 2'b00}) else $error("temperature read mismatch");
  a_pin_cause: assert property ($changed(limit_out_first) || $changed(limit_out_second)
    |-> $past(conv_in.valid, 2) || $past(bus_cmd_valid, 2) || $past(acc, 2))
    else $error("alert pin moved without cause");
  a_irq_cause: assert property ($rose(irq)
    |-> $past(conv_in.valid, 2) || $past(acc && pwrite, 2)) else $error("irq rose without cause");
  a_clear_cmd: assert property (s_clr_first |=> ##1 limit_out_first == cfg_ff[7])
    else $error("clear command did not release first pin");
  a_therm_cmd: assert property (bus_cmd_valid && cfg_ff[2] && !conv_in.valid
    && !$past(conv_in.valid) |=> $stable(limit_out_second)[*2]) else $error("therm pin cleared");
  a_therm_under: assert property (acc && !pwrite && paddr == 32'h4 && cfg_ff[2]
    |-> !prdata[0]) else $error("therm under flag not zero");
endmodule : temp_alert_chk
bind temp_result_limit_alert temp_alert_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .conv_in, .bus_cmd, .bus_cmd_valid,
  .limit_out_first, .limit_out_second, .irq);
`default_nettype wire

// [test/tb_temp_result_limit_alert.sv]
// Self-checking bench for the temperature alert block
`timescale 1ns/100ps
`default_nettype none
module tb_temp_result_limit_alert;
  import temp_alert_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, send;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] code, bus_cmd;
  logic bus_cmd_valid, limit_out_first, limit_out_second;
  logic [15:0] lfsr;
  logic [32:0] exp_q[$];
  conv_t conv_in;
  int bad_count = 0;
  int tests_run = 0;
  temp_result_limit_alert DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .conv_in, .bus_cmd, .bus_cmd_valid,
    .limit_out_first, .limit_out_second, .irq);
  alert_host_model host (.pclk, .presetn, .send, .code, .bus_cmd, .bus_cmd_valid);
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic cmp(input logic [32:0] e, input logic [32:0] a);
    tests_run++;
    if (a !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask : cmp
  task automatic check_out(input logic [2:0] e);
    repeat (2) @(posedge pclk);
    cmp({30'h0, e}, {30'h0, irq, limit_out_second, limit_out_first});
  endtask : check_out
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
      input logic [32:0] e);
    int n;
    @(posedge pclk);
    if (!w) exp_q.push_back(e);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    apb(a, 1'b0, 32'h0, e);
  endtask : rd
  task automatic conv(input logic [13:0] c);
    @(posedge pclk);
    conv_in <= {1'b1, c};
    @(posedge pclk);
    conv_in.valid <= 1'b0;
  endtask : conv
  task automatic cmd(input logic [7:0] c);
    @(posedge pclk);
    send <= 1'b1;
    code <= c;
    @(posedge pclk);
    send <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : cmd
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      cmp(exp_q.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, send, code, paddr, pwdata} = '0;
    conv_in = '0;
    lfsr = 16'd37278;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(32'h8 + 4 * i, {17'h0, i[0] ? 16'h8000 : 16'h7ffc});
    end
    rd(32'h4, 33'h0);
    rd(32'h1000, {1'b1, 32'h0});
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      conv(lfsr[13:0]);
      rd(32'h0, {17'h0, lfsr[13:0], 2'b00});
    end
    check_out(3'b000);
    wr(32'h20, 32'h3);
    wr(32'h8, 32'h1900);
    wr(32'hc, 32'he700);
    conv(14'h0c80);
    check_out(3'b101);
    rd(32'h4, 33'h20);
    check_out(3'b100);
    rd(32'h4, 33'h0);
    rd(32'h1c, 33'h1);
    wr(32'h20, 32'h0);
    check_out(3'b000);
    wr(32'h24, 32'h3);
    rd(32'h1c, 33'h0);
    conv(14'h3240);
    check_out(3'b001);
    cmd(8'hb5);
    check_out(3'b000);
    rd(32'h4, 33'h10);
    wr(32'h8, 32'h7ffc);
    wr(32'hc, 32'h8000);
    wr(32'h10, 32'h1900);
    wr(32'h14, 32'h0c80);
    wr(32'h4, 32'h84);
    conv(14'h0c80);
    check_out(3'b011);
    rd(32'h4, 33'h86);
    cmd(8'h75);
    conv(14'h0500);
    check_out(3'b011);
    conv(14'h0000);
    check_out(3'b001);
    wr(32'h4, 32'h0c);
    check_out(3'b010);
    tally_and_finish();
  end
endmodule : tb_temp_result_limit_alert
`default_nettype wire
